// ===== rtl/cpap_control_panel_fsm.v
// control-panel logic: power, charger lock-out, battery LEDs, low-battery alarm, display cycle,
// settings menu, hour meter and ramp, with an APB register slave and one interrupt line
// assumes all inputs but the three buttons synchronous to pclk; nonvolatile store sits outside and answers nv_load
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cpap_consts.vh"

// Summary of operation
// (RULE_01) power press toggles off and running
// (RULE_02) three LEDs show battery charge level
// (RULE_03) alarm sounds at ten minutes left
// (RULE_04) power press silences sounding alarm
// (RULE_05) charger attached: ignore power, stay off
// (RULE_06) charger light red, orange, then green
// (RULE_07) power-on shows four items three times
// (RULE_08) display only while powered on
// (RULE_09) three-second set hold enters menu, airflow stops
// (RULE_10) change press flips shown option
// (RULE_11) set steps items, then exits and saves
// (RULE_12) hour meter counts use, shown as item
// (RULE_13) ramp rises to prescription over fifteen minutes
// (RULE_14) double power press restarts the ramp
// (RULE_15) two-state altitude compensation setting held
// (RULE_16) settings and hours kept in nonvolatile store
// (RULE_17) buttons debounced; hold timer resets on release
// (RULE_18) ramp starts lower, rises monotonically to target
module cpap_control_panel_fsm #(
	parameter TICK_CYC = `CLK_HZ / `TICK_HZ,
	parameter DEB_MS = `DEB_MS,
	parameter HOLD_MS = `HOLD_MS,
	parameter DWELL_MS = `DWELL_MS,
	parameter RAMP_MS = `RAMP_MIN * `MS_PER_MIN,
	parameter HOUR_MS = `HOUR_MIN * `MS_PER_MIN,
	parameter [15:0] FW_VERSION = 16'h0100
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq,
	// buttons and sense, active high
	input wire power_btn,
	input wire set_btn,
	input wire change_btn,
	input wire charger_present,
	input wire [7:0] battery_pct,
	input wire [7:0] runtime_left_min,
	// nonvolatile store
	input wire nv_load,
	input wire nv_alt_in,
	input wire nv_ramp_in,
	input wire [15:0] nv_hours_in,
	output reg nv_write,
	output reg nv_alt_out,
	output reg nv_ramp_out,
	output reg [15:0] nv_hours_out,
	// indicators and actuators
	output reg [2:0] batt_led,
	output reg chg_red,
	output reg chg_orange,
	output reg chg_green,
	output reg buzzer,
	output reg disp_on,
	output reg [1:0] disp_item,
	output reg [15:0] disp_value,
	output reg blower_en,
	output reg [7:0] pressure_target
);

	// millisecond tick
	reg [31:0] tick_cnt_reg;
	reg tick_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg >= TICK_CYC - 1) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
			tick_reg <= 1'b0;
		end
	end

	// button synchronisers and debouncers: 0 power, 1 set, 2 change
	wire [2:0] btn_raw = {change_btn, set_btn, power_btn};
	wire [2:0] btn_deb;
	wire [2:0] btn_press;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_btn
			reg meta_reg;
			reg sync_reg;
			reg deb_reg;
			reg deb_d_reg;
			reg [7:0] stab_reg;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					deb_reg <= 1'b0;
					deb_d_reg <= 1'b0;
					stab_reg <= 8'h00;
				end else begin
					meta_reg <= btn_raw[gi];
					sync_reg <= meta_reg;
					deb_d_reg <= deb_reg;
					if (sync_reg == deb_reg) begin
						stab_reg <= 8'h00;
					end else if (tick_reg) begin
						if (stab_reg >= DEB_MS - 1) begin
							deb_reg <= sync_reg; // RULE_17
							stab_reg <= 8'h00;
						end else begin
							stab_reg <= stab_reg + 8'h01;
						end
					end
				end
			end
			assign btn_deb[gi] = deb_reg;
			assign btn_press[gi] = deb_reg & ~deb_d_reg;
		end
	endgenerate

	// registers seen by software
	reg [31:0] ctrl_reg;
	reg [`IRQ_BITS-1:0] irq_stat_reg;
	reg [`IRQ_BITS-1:0] irq_en_reg;
	reg [`IRQ_BITS-1:0] irq_clr;
	reg [`IRQ_BITS-1:0] events;

	// panel state
	reg [1:0] state_reg;
	reg [1:0] item_reg;
	reg [1:0] pass_reg;
	reg [31:0] dwell_reg;
	reg [31:0] hold_reg;
	reg hold_done_reg;
	reg alt_reg;
	reg ramp_reg;
	reg alt_work_reg;
	reg ramp_work_reg;
	reg [15:0] hours_reg;
	reg [31:0] use_ms_reg;
	reg silenced_reg;
	reg charger_d_reg;
	reg ramp_act_reg;
	reg [31:0] ramp_acc_reg;
	reg [7:0] ramp_level_reg;

	wire running = (state_reg == `ST_SHOW) || (state_reg == `ST_RUN);
	wire powered = state_reg != `ST_OFF;
	wire alarm_cond = running && (runtime_left_min <= `ALARM_MIN);
	wire [7:0] presc = ctrl_reg[`CTRL_PRESC];
	wire [7:0] drop = (ctrl_reg[`CTRL_RDROP] > presc) ? presc : ctrl_reg[`CTRL_RDROP];
	wire hour_wrap = blower_en && tick_reg && (use_ms_reg >= HOUR_MS - 1);
	wire menu_exit = (state_reg == `ST_MENU) && btn_press[1] && (item_reg == 2'h2);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= `ST_OFF;
			item_reg <= 2'h0;
			pass_reg <= 2'h0;
			dwell_reg <= 32'h0;
			hold_reg <= 32'h0;
			hold_done_reg <= 1'b0;
			alt_reg <= 1'b0;
			ramp_reg <= 1'b0;
			alt_work_reg <= 1'b0;
			ramp_work_reg <= 1'b0;
			hours_reg <= 16'h0000;
			use_ms_reg <= 32'h0;
			silenced_reg <= 1'b0;
			charger_d_reg <= 1'b0;
			ramp_act_reg <= 1'b0;
			ramp_acc_reg <= 32'h0;
			ramp_level_reg <= 8'h00;
			events <= {`IRQ_BITS{1'b0}};
		end else begin
			events <= {`IRQ_BITS{1'b0}};
			charger_d_reg <= charger_present;
			if (charger_present && !charger_d_reg) begin
				events[`IRQ_CHARGER] <= 1'b1;
			end
			// stored values arrive after reset from the nonvolatile store
			if (nv_load) begin
				alt_reg <= nv_alt_in; // RULE_16
				ramp_reg <= nv_ramp_in; // RULE_16
				hours_reg <= nv_hours_in; // RULE_16
			end else if (hour_wrap) begin
				hours_reg <= hours_reg + 16'h0001; // RULE_12
			end
			if (blower_en && tick_reg) begin
				use_ms_reg <= hour_wrap ? 32'h0 : use_ms_reg + 32'h1; // RULE_12
			end
			if (!alarm_cond) begin
				silenced_reg <= 1'b0;
			end else if (btn_press[0] && buzzer && !charger_present) begin
				silenced_reg <= 1'b1; // RULE_04
			end
			if (alarm_cond && !silenced_reg && !buzzer) begin
				events[`IRQ_ALARM] <= 1'b1;
			end
			// hold timer runs only while set is held in a running state
			if (!btn_deb[1] || !running) begin
				hold_reg <= 32'h0; // RULE_17
				hold_done_reg <= 1'b0;
			end else if (tick_reg && !hold_done_reg) begin
				if (hold_reg >= HOLD_MS - 1) begin
					hold_done_reg <= 1'b1; // RULE_09
				end
				hold_reg <= hold_reg + 32'h1;
			end
			// ramp accumulator: one step each time the drop share of RAMP_MS has passed
			if (ramp_act_reg && blower_en && tick_reg) begin
				if (ramp_level_reg >= drop) begin
					ramp_act_reg <= 1'b0;
				end else if (ramp_acc_reg + {24'h0, drop} >= RAMP_MS) begin
					ramp_acc_reg <= ramp_acc_reg + {24'h0, drop} - RAMP_MS;
					ramp_level_reg <= ramp_level_reg + 8'h01; // RULE_18
				end else begin
					ramp_acc_reg <= ramp_acc_reg + {24'h0, drop}; // RULE_13
				end
			end
			if (charger_present) begin
				state_reg <= `ST_OFF; // RULE_05
			end else if (btn_press[0] && !buzzer) begin
				events[`IRQ_POWER] <= 1'b1;
				if (state_reg == `ST_OFF) begin
					state_reg <= `ST_SHOW; // RULE_01
					item_reg <= `ITEM_VER;
					pass_reg <= 2'h0;
					dwell_reg <= 32'h0;
					ramp_act_reg <= ramp_reg; // RULE_14
					ramp_acc_reg <= 32'h0;
					ramp_level_reg <= 8'h00;
				end else begin
					state_reg <= `ST_OFF; // RULE_01
				end
			end else begin
				case (state_reg)
					`ST_SHOW: begin
						if (hold_done_reg && !hold_reg[31]) begin
							state_reg <= `ST_MENU;
						end else if (tick_reg) begin
							if (dwell_reg >= DWELL_MS - 1) begin
								dwell_reg <= 32'h0;
								item_reg <= item_reg + 2'h1; // RULE_07
								if (item_reg == `ITEM_HOURS) begin
									pass_reg <= pass_reg + 2'h1;
									if (pass_reg == `SHOW_PASSES - 2'h1) begin
										state_reg <= `ST_RUN; // RULE_07
									end
								end
							end else begin
								dwell_reg <= dwell_reg + 32'h1;
							end
						end
					end
					`ST_RUN: begin
						if (hold_done_reg) begin
							state_reg <= `ST_MENU;
						end
					end
					`ST_MENU: begin
						if (btn_press[1]) begin
							if (item_reg == 2'h2) begin
								alt_reg <= alt_work_reg; // RULE_11
								ramp_reg <= ramp_work_reg; // RULE_11
								state_reg <= `ST_SHOW;
								item_reg <= `ITEM_VER;
								pass_reg <= 2'h0;
								dwell_reg <= 32'h0;
							end else begin
								item_reg <= item_reg + 2'h1; // RULE_11
							end
						end else if (btn_press[2]) begin
							if (item_reg == 2'h0) begin
								alt_work_reg <= ~alt_work_reg; // RULE_10
							end
							if (item_reg == 2'h1) begin
								ramp_work_reg <= ~ramp_work_reg; // RULE_10
							end
						end
					end
					default: begin
						state_reg <= `ST_OFF;
					end
				endcase
			end
			// menu entry: start from the altitude item with the stored values
			if (running && hold_done_reg && !charger_present && !(btn_press[0] && !buzzer)) begin
				state_reg <= `ST_MENU; // RULE_09
				item_reg <= 2'h0;
				alt_work_reg <= alt_reg; // RULE_15
				ramp_work_reg <= ramp_reg;
				events[`IRQ_MENU] <= 1'b1;
			end
		end
	end

	// outputs, all registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			batt_led <= 3'b000;
			chg_red <= 1'b0;
			chg_orange <= 1'b0;
			chg_green <= 1'b0;
			buzzer <= 1'b0;
			disp_on <= 1'b0;
			disp_item <= `ITEM_VER;
			disp_value <= 16'h0000;
			blower_en <= 1'b0;
			pressure_target <= 8'h00;
			nv_write <= 1'b0;
			nv_alt_out <= 1'b0;
			nv_ramp_out <= 1'b0;
			nv_hours_out <= 16'h0000;
		end else begin
			if (!powered) begin
				batt_led <= 3'b000;
			end else if (battery_pct >= `LED3_PCT) begin
				batt_led <= 3'b111; // RULE_02
			end else if (battery_pct >= `LED2_PCT) begin
				batt_led <= 3'b011; // RULE_02
			end else begin
				batt_led <= 3'b001; // RULE_02
			end
			chg_red <= charger_present && (battery_pct < `CHG_ORANGE_PCT); // RULE_06
			chg_orange <= charger_present && (battery_pct >= `CHG_ORANGE_PCT) && (battery_pct < `CHG_GREEN_PCT);
			chg_green <= charger_present && (battery_pct >= `CHG_GREEN_PCT); // RULE_06
			buzzer <= alarm_cond && !silenced_reg && !(btn_press[0] && buzzer); // RULE_03
			disp_on <= (state_reg == `ST_SHOW) || (state_reg == `ST_MENU); // RULE_08
			if (state_reg == `ST_MENU) begin
				disp_item <= item_reg + 2'h1;
				case (item_reg)
					2'h0: disp_value <= {15'h0000, alt_work_reg};
					2'h1: disp_value <= {15'h0000, ramp_work_reg};
					default: disp_value <= hours_reg; // RULE_12
				endcase
			end else if (state_reg == `ST_SHOW) begin
				disp_item <= item_reg;
				case (item_reg)
					`ITEM_VER: disp_value <= FW_VERSION;
					`ITEM_ALT: disp_value <= {15'h0000, alt_reg};
					`ITEM_RAMP: disp_value <= {15'h0000, ramp_reg};
					default: disp_value <= hours_reg; // RULE_12
				endcase
			end else begin
				disp_item <= `ITEM_VER; // RULE_08
				disp_value <= 16'h0000;
			end
			blower_en <= running; // RULE_09
			if (!running) begin
				pressure_target <= 8'h00;
			end else if (ramp_act_reg) begin
				pressure_target <= presc - drop + ramp_level_reg; // RULE_13
			end else begin
				pressure_target <= presc;
			end
			nv_write <= menu_exit || hour_wrap; // RULE_16
			if (menu_exit) begin
				nv_alt_out <= alt_work_reg;
				nv_ramp_out <= ramp_work_reg;
			end else begin
				nv_alt_out <= alt_reg;
				nv_ramp_out <= ramp_reg;
			end
			nv_hours_out <= hour_wrap ? hours_reg + 16'h0001 : hours_reg;
		end
	end

	// apb slave: data prepared in the first access cycle, write lands when pready is seen
	wire acc_first = psel && penable && !pready;
	wire acc_done = psel && penable && pready;
	wire wr_done = acc_done && pwrite && !pslverr;
	wire mapped = (paddr == `CTRL_OFS) || (paddr == `STATUS_OFS) || (paddr == `IRQ_STAT_OFS) ||
		(paddr == `IRQ_CLR_OFS) || (paddr == `IRQ_EN_OFS);

	always @* begin
		irq_clr = {`IRQ_BITS{1'b0}};
		if (wr_done && (paddr == `IRQ_CLR_OFS)) begin
			irq_clr = pwdata[`IRQ_BITS-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ctrl_reg <= `CTRL_RESET;
			irq_en_reg <= {`IRQ_BITS{1'b0}};
			irq_stat_reg <= {`IRQ_BITS{1'b0}};
			irq <= 1'b0;
		end else begin
			pready <= acc_first;
			pslverr <= acc_first && !mapped;
			if (acc_first) begin
				case (paddr)
					`CTRL_OFS: prdata <= ctrl_reg;
					`STATUS_OFS: prdata <= {ramp_act_reg, 7'h00, hours_reg, buzzer, blower_en,
						ramp_reg, alt_reg, 2'h0, state_reg};
					`IRQ_STAT_OFS: prdata <= {28'h0, irq_stat_reg};
					`IRQ_EN_OFS: prdata <= {28'h0, irq_en_reg};
					default: prdata <= 32'h0;
				endcase
			end
			if (wr_done && (paddr == `CTRL_OFS)) begin
				ctrl_reg <= {16'h0000, pwdata[15:0]};
			end
			if (wr_done && (paddr == `IRQ_EN_OFS)) begin
				irq_en_reg <= pwdata[`IRQ_BITS-1:0];
			end
			// a new event wins over a clear in the same cycle
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | events;
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

endmodule // cpap_control_panel_fsm
`default_nettype wire

// ===== rtl/cpap_consts.vh
// constants for the control-panel logic: register map, field layout, reset values, timing
// included by the control-panel module; holds definitions only
`ifndef CPAP_CONSTS_VH
`define CPAP_CONSTS_VH

// register byte offsets
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define IRQ_STAT_OFS 8'h08
`define IRQ_CLR_OFS 8'h0C
`define IRQ_EN_OFS 8'h10

// control register fields and reset value
`define CTRL_PRESC 7:0
`define CTRL_RDROP 15:8
`define CTRL_RESET 32'h0000040A

// interrupt bit positions
`define IRQ_ALARM 0
`define IRQ_POWER 1
`define IRQ_MENU 2
`define IRQ_CHARGER 3
`define IRQ_BITS 4

// states
`define ST_OFF 2'h0
`define ST_SHOW 2'h1
`define ST_RUN 2'h2
`define ST_MENU 2'h3

// display items
`define ITEM_VER 2'h0
`define ITEM_ALT 2'h1
`define ITEM_RAMP 2'h2
`define ITEM_HOURS 2'h3

// timing
`define CLK_HZ 25000000
`define TICK_HZ 1000
`define DEB_MS 20
`define HOLD_MS 3000
`define DWELL_MS 2000
`define RAMP_MIN 15
`define HOUR_MIN 60
`define MS_PER_MIN 60000
`define ALARM_MIN 8'h0A
`define SHOW_PASSES 2'h3

// battery thresholds in percent
`define LED3_PCT 8'h5F
`define LED2_PCT 8'h4B
`define LED1_PCT 8'h3C
`define CHG_ORANGE_PCT 8'h32
`define CHG_GREEN_PCT 8'h64

`endif

// ===== tb/cpap_panel_chk.sv
// checker on the control-panel ports: apb answer, leds, charger lock-out, alarm
// bound into every control panel at the foot; sees its ports only
`timescale 1ns/1ns
`default_nettype none
module cpap_panel_chk (
	// clock, reset, apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// panel
	input wire logic charger_present,
	input wire logic [7:0] battery_pct,
	input wire logic [7:0] runtime_left_min,
	input wire logic [2:0] batt_led,
	input wire logic chg_red,
	input wire logic chg_orange,
	input wire logic chg_green,
	input wire logic buzzer,
	input wire logic disp_on,
	input wire logic [15:0] disp_value,
	input wire logic blower_en,
	input wire logic [7:0] pressure_target
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	// six steady cycles cover any input synchroniser on the charger sense
	sequence s_plug;
		(charger_present && $stable(battery_pct)) [*6];
	endsequence
	property p_ready; s_acc |=> pready ##1 !pready; endproperty
	a_ready: assert property (p_ready) else $error("apb answer timing wrong");
	property p_err; pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0) &&
		(!pslverr || prdata == 32'h0); endproperty
	a_err: assert property (p_err) else $error("apb error flag wrong");
	property p_led; blower_en |=> !blower_en || batt_led == ($past(battery_pct) >= 8'h5F ? 3'h7 :
		$past(battery_pct) >= 8'h4B ? 3'h3 : 3'h1); endproperty
	a_led: assert property (p_led) else $error("battery leds wrong");
	property p_off; !blower_en && !disp_on |-> batt_led == 3'h0 && disp_value == 16'h0; endproperty
	a_off: assert property (p_off) else $error("indication while off");
	property p_tgt; !blower_en |-> pressure_target == 8'h00; endproperty
	a_tgt: assert property (p_tgt) else $error("target without airflow");
	property p_lock; charger_present [*6] |-> !blower_en && !disp_on; endproperty
	a_lock: assert property (p_lock) else $error("running on charger");
	property p_col; s_plug |-> {chg_red, chg_orange, chg_green} == (battery_pct >= 8'h64 ? 3'h1 :
		battery_pct >= 8'h32 ? 3'h2 : 3'h4); endproperty
	a_col: assert property (p_col) else $error("charger colour wrong");
	property p_alarm; $rose(buzzer) |-> $past(runtime_left_min) <= 8'h0A; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm too early");
endmodule // cpap_panel_chk
bind cpap_control_panel_fsm cpap_panel_chk cpap_panel_chk_inst (.*);
`default_nettype wire

// ===== tb/cpap_user_side.sv
// user and nonvolatile store around the panel: chattering buttons, settings memory
// assumes press() is called right after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module cpap_user_side (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// buttons and store
	output wire logic power_btn,
	output wire logic set_btn,
	output wire logic change_btn,
	output wire logic nv_load,
	output wire logic nv_alt_in,
	output wire logic nv_ramp_in,
	output wire logic [15:0] nv_hours_in,
	input wire logic nv_write,
	input wire logic nv_alt_out,
	input wire logic nv_ramp_out,
	input wire logic [15:0] nv_hours_out
);
	logic [2:0] btn = 3'h0;
	// alt off, ramp on, five hours: a used unit rather than a blank one
	logic [17:0] store = 18'h10005;
	logic ld = 1'b0;
	logic up = 1'b0;
	assign {change_btn, set_btn, power_btn} = btn;
	assign {nv_alt_in, nv_ramp_in, nv_hours_in} = store;
	assign nv_load = ld;
	always @(posedge pclk) begin
		ld <= presetn && !up;
		up <= presetn;
		if (nv_write)
			store <= {nv_alt_out, nv_ramp_out, nv_hours_out};
	end
	// contacts chatter for three cycles; a panel that counts chatter sees extra presses
	task automatic press(input int b, input int hold);
		repeat (3) begin
			@(posedge pclk);
			btn[b] <= ~btn[b];
		end
		repeat (hold) @(posedge pclk);
		btn[b] <= 1'b0;
		repeat (20) @(posedge pclk);
	endtask
endmodule // cpap_user_side
`default_nettype wire

// ===== tb/tb_cpap_control_panel_fsm.sv
// bench for the control panel: apb tasks, display-order model, scenario list
// assumes the user-side model for buttons and store; counts shortened by parameters
`timescale 1ns/1ns
`default_nettype none
module tb_cpap_control_panel_fsm;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, charger_present = 1'b0;
	logic [7:0] paddr = 8'h00, battery_pct = 8'h64, runtime_left_min = 8'h50, presc, pressure_target, lv[6], cv[3];
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, irq, power_btn, set_btn, change_btn, nv_load, nv_alt_in, nv_ramp_in, nv_write, e;
	logic nv_alt_out, nv_ramp_out, buzzer, disp_on, blower_en, chg_red, chg_orange, chg_green, on_q = 1'b0;
	logic [15:0] nv_hours_in, nv_hours_out, disp_value;
	logic [2:0] batt_led;
	logic [1:0] disp_item, item_q, nvq, seen[$];
	int bad_count = 0, check_count = 0;
	cpap_control_panel_fsm #(.TICK_CYC(4), .DEB_MS(2), .HOLD_MS(10), .DWELL_MS(3), .RAMP_MS(40), .HOUR_MS(50))
		cpap_control_panel_fsm_inst (.*);
	cpap_user_side cpap_user_side_inst (.*);
	initial forever #20 pclk = ~pclk;
	// model side: order of shown items and last stored settings
	always @(posedge pclk) begin
		if (disp_on && (!on_q || disp_item !== item_q))
			seen.push_back(disp_item);
		if (nv_write)
			nvq = {nv_alt_out, nv_ramp_out};
		on_q = disp_on;
		item_q = disp_item;
	end
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a slave that never answers counts against the run
		if (pready !== 1'b1)
			bad_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wt(ref logic s, input logic v);
		int n = 0;
		while (s !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		chk(s, v);
	endtask
	task automatic pr(input int b, input int h);
		cpap_user_side_inst.press(b, h);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// the scenarios need about 1200 cycles; the 20000-cycle limit means a hang
	initial begin
		#800000;
		bad_count++;
		print_verdict();
	end
	initial begin
		r = $urandom(32'h0414E6F4);
		lv = '{8'h5F, 8'h5E, 8'h4B, 8'h4A, 8'h3C, 8'h00};
		lv[5] = 8'($urandom);
		cv = '{8'h31, 8'h63, 8'h64};
		presc = 8'h10 + 8'($urandom_range(15));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0000040A);
		apb(1'b1, 8'h00, {16'($urandom), 8'h04, presc});
		apb(1'b0, 8'h00, 32'h0);
		chk(r, {16'h0, 8'h04, presc});
		apb(1'b0, 8'h14, 32'h0);
		chk({r, e}, 33'h1);
		apb(1'b1, 8'h04, 32'hFFFFFFFF);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, 32'h00000520);
		apb(1'b1, 8'h10, 32'h2);
		$display("test registers end");
		seen.delete();
		pr(0, 20);
		wt(blower_en, 1'b1);
		chk(pressure_target, presc - 8'h04);
		wt(irq, 1'b1);
		foreach (lv[i]) begin
			battery_pct <= lv[i];
			repeat (3) @(posedge pclk);
			chk(batt_led, lv[i] >= 8'h5F ? 3'h7 : lv[i] >= 8'h4B ? 3'h3 : 3'h1);
		end
		wt(disp_on, 1'b0);
		chk(seen.size(), 12);
		foreach (seen[i]) chk(seen[i], i % 4);
		repeat (200) @(posedge pclk);
		chk(pressure_target, presc);
		apb(1'b0, 8'h08, 32'h0);
		chk(r, 32'h2);
		apb(1'b1, 8'h0C, 32'h2);
		apb(1'b0, 8'h08, 32'h0);
		chk({r, irq}, 33'h0);
		$display("test power-on end");
		runtime_left_min <= 8'($urandom_range(10));
		wt(buzzer, 1'b1);
		chk(irq, 1'b0);
		pr(0, 20);
		chk({buzzer, blower_en}, 2'h1);
		runtime_left_min <= 8'h0B + 8'($urandom_range(244));
		pr(1, 30);
		pr(1, 30);
		chk(blower_en, 1'b1);
		pr(1, 80);
		chk({blower_en, disp_item}, 3'h1);
		pr(2, 20);
		chk(disp_value, 16'h1);
		pr(1, 20);
		chk({disp_item, disp_value}, 18'h20001);
		// ramp flipped twice: both states seen, and it is saved on for the restart test
		pr(2, 20);
		chk(disp_value, 16'h0);
		pr(2, 20);
		chk(disp_value, 16'h1);
		pr(1, 20);
		apb(1'b0, 8'h04, 32'h0);
		chk({disp_item, disp_value}, {2'h3, r[23:8]});
		pr(1, 20);
		chk({blower_en, nvq}, 3'h7);
		$display("test menu end");
		apb(1'b1, 8'h10, 32'h0);
		pr(0, 20);
		chk(blower_en, 1'b0);
		pr(0, 20);
		chk({blower_en, pressure_target, irq}, {1'b1, presc - 8'h04, 1'b0});
		apb(1'b1, 8'h10, 32'h2);
		wt(irq, 1'b1);
		pr(0, 20);
		charger_present <= 1'b1;
		foreach (cv[i]) begin
			battery_pct <= cv[i];
			repeat (8) @(posedge pclk);
			chk({chg_red, chg_orange, chg_green}, 3'h4 >> i);
		end
		pr(0, 20);
		chk(blower_en, 1'b0);
		charger_present <= 1'b0;
		pr(0, 20);
		wt(blower_en, 1'b1);
		// alarm, power, menu and charger events have all happened and only power was cleared
		apb(1'b0, 8'h08, 32'h0);
		chk(r, 32'h0000000F);
		$display("test charger end");
		print_verdict();
	end
endmodule // tb_cpap_control_panel_fsm
`default_nettype wire
